// file: logic/licfg_top.sv
`timescale 1ns/1ps
module licfg_top
  import licfg_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // SPI pins
  input  wire logic       spi_sclk,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_mosi,
  output logic            spi_miso,
  // Device state
  input  wire logic       init_mode,
  input  wire logic       low_power_mode,
  input  wire logic       cyclic_sense_sel,
  input  wire logic       cyclic_active_time,
  input  wire logic       overvoltage_main,
  input  wire logic       overvoltage_aux,
  // Driver requests from I/O control
  input  wire logic       io0_hs_req,
  input  wire logic       io0_ls_req,
  input  wire logic       io1_hs_req,
  input  wire logic       io1_ls_req,
  // Driver enables
  output logic            io0_hs_en,
  output logic            io0_ls_en,
  output logic            io1_hs_en,
  output logic            io1_ls_en,
  // Multipurpose pin functions
  output logic            first_multipin_lin_switch,
  output logic            first_multipin_hs_wake,
  output logic            second_multipin_hs_wake,
  // Register view
  output logic [7:0]      lin_io_init_config
);

  // ----------------------------------------------------------------
  // Frame reception
  // ----------------------------------------------------------------
  logic                  frame_valid;
  logic [FRAME_BITS-1:0] frame_word;
  logic [FRAME_BITS-1:0] tx_word;

  assign tx_word = {READ_HEADER, lin_io_init_config};

  licfg_spi_rx u_spi_rx (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .spi_sclk    (spi_sclk),
    .spi_cs_n    (spi_cs_n),
    .spi_mosi    (spi_mosi),
    .spi_miso    (spi_miso),
    .tx_word     (tx_word),
    .frame_valid (frame_valid),
    .frame_word  (frame_word)
  );

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  logic cfg_hit;

  // Parity bit is carried but checked elsewhere in the device
  assign cfg_hit = frame_valid
                && (frame_word[CMD_MSB:CMD_LSB] == CMD_WRITE)
                && (frame_word[ADDR_MSB:ADDR_LSB] == CFG_ADDR);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lin_io_init_config <= CFG_RESET;
    end else if (cfg_hit && init_mode) begin
      lin_io_init_config <= frame_word[DATA_MSB:0];
    end
  end

  // ----------------------------------------------------------------
  // Multipurpose pin decode
  // ----------------------------------------------------------------
  // Returns {hs_wake, lin_switch}; unused codes leave the pin off
  function automatic logic [1:0] mp_decode(input logic [1:0] code, input logic lin_allowed);
    logic [1:0] res;
    res = 2'h0;
    case (code)
      MP_LIN_SWITCH: res = {1'b0, lin_allowed};
      MP_HS_WAKE:    res = 2'h2;
      MP_OFF:        res = 2'h0;
      default:       res = 2'h0;
    endcase
    return res;
  endfunction

  logic [1:0] mp1_dec;
  logic [1:0] mp2_dec;

  assign mp1_dec = mp_decode(lin_io_init_config[MP1_MSB:MP1_LSB], 1'b1);
  assign mp2_dec = mp_decode(lin_io_init_config[MP2_MSB:MP2_LSB], 1'b0);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      first_multipin_lin_switch <= 1'b0;
      first_multipin_hs_wake    <= 1'b0;
      second_multipin_hs_wake   <= 1'b0;
    end else begin
      first_multipin_lin_switch <= mp1_dec[0];
      first_multipin_hs_wake    <= mp1_dec[1];
      second_multipin_hs_wake   <= mp2_dec[1];
    end
  end

  // ----------------------------------------------------------------
  // Second I/O drivers
  // ----------------------------------------------------------------
  logic io1_kill;

  assign io1_kill = lin_io_init_config[OVOFF_BIT] && (overvoltage_main || overvoltage_aux);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      io1_hs_en <= 1'b0;
      io1_ls_en <= 1'b0;
    end else if (!lin_io_init_config[IO1_OE_BIT] || io1_kill) begin
      io1_hs_en <= 1'b0;
      io1_ls_en <= 1'b0;
    end else begin
      // High side wins so the pin never shoots through
      io1_hs_en <= io1_hs_req;
      io1_ls_en <= io1_ls_req && !io1_hs_req;
    end
  end

  // ----------------------------------------------------------------
  // First I/O drivers and low-power cyclic sense
  // ----------------------------------------------------------------
  licfg_lp_t lp_state;
  licfg_lp_t next_lp_state;
  logic      saved_hs;
  logic      saved_ls;
  logic      next_hs;
  logic      next_ls;
  logic      io0_oe;

  assign io0_oe = lin_io_init_config[IO0_OE_BIT];

  always_comb begin
    next_lp_state = lp_state;
    case (lp_state)
      LP_AWAKE: begin
        if (low_power_mode) begin
          next_lp_state = LP_HOLD;
        end
      end
      LP_HOLD, LP_ACTIVE, LP_OFF: begin
        if (!low_power_mode) begin
          next_lp_state = LP_AWAKE;
        end else if (!cyclic_sense_sel) begin
          next_lp_state = LP_HOLD;
        end else if (cyclic_active_time) begin
          next_lp_state = LP_ACTIVE;
        end else begin
          next_lp_state = LP_OFF;
        end
      end
      default: next_lp_state = LP_AWAKE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lp_state <= LP_AWAKE;
    end else begin
      lp_state <= next_lp_state;
    end
  end

  // Snapshot of the driver state at entry into low power
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      saved_hs <= 1'b0;
      saved_ls <= 1'b0;
    end else if (lp_state == LP_AWAKE && low_power_mode) begin
      saved_hs <= io0_hs_en;
      saved_ls <= io0_ls_en;
    end
  end

  always_comb begin
    next_hs = 1'b0;
    next_ls = 1'b0;
    case (lp_state)
      LP_AWAKE: begin
        next_hs = io0_oe && io0_hs_req;
        next_ls = io0_oe && io0_ls_req && !io0_hs_req;
      end
      LP_HOLD, LP_ACTIVE: begin
        next_hs = io0_oe && saved_hs;
        next_ls = io0_oe && saved_ls;
      end
      LP_OFF: begin
        if (lin_io_init_config[CYC_INV_BIT]) begin
          next_hs = io0_oe && saved_ls;
          next_ls = io0_oe && saved_hs;
        end else begin
          next_hs = 1'b0;
          next_ls = 1'b0;
        end
      end
      default: begin
        next_hs = 1'b0;
        next_ls = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      io0_hs_en <= 1'b0;
      io0_ls_en <= 1'b0;
    end else begin
      io0_hs_en <= next_hs;
      io0_ls_en <= next_ls;
    end
  end

endmodule

// file: include/licfg_pkg.sv
package licfg_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int          FRAME_BITS    = 16;
  localparam logic [4:0]  FRAME_COUNT   = 5'h10;
  localparam int          CMD_MSB       = 15;
  localparam int          CMD_LSB       = 14;
  localparam int          ADDR_MSB      = 13;
  localparam int          ADDR_LSB      = 9;
  localparam int          PARITY_BIT    = 8;
  localparam int          DATA_MSB      = 7;
  localparam logic [1:0]  CMD_WRITE     = 2'h1;
  localparam logic [4:0]  CFG_ADDR      = 5'h07;
  localparam logic [7:0]  READ_HEADER   = 8'h00;

  // ----------------------------------------------------------------
  // Configuration register fields
  // ----------------------------------------------------------------
  localparam int          OVOFF_BIT     = 7;
  localparam int          MP2_MSB       = 6;
  localparam int          MP2_LSB       = 5;
  localparam int          MP1_MSB       = 4;
  localparam int          MP1_LSB       = 3;
  localparam int          IO1_OE_BIT    = 2;
  localparam int          IO0_OE_BIT    = 1;
  localparam int          CYC_INV_BIT   = 0;
  localparam logic [7:0]  CFG_RESET     = 8'h00;

  // ----------------------------------------------------------------
  // Multipurpose pin function codes
  // ----------------------------------------------------------------
  localparam logic [1:0]  MP_OFF        = 2'h0;
  localparam logic [1:0]  MP_LIN_SWITCH = 2'h1;
  localparam logic [1:0]  MP_HS_WAKE    = 2'h2;
  localparam logic [1:0]  MP_NONE       = 2'h3;

  // ----------------------------------------------------------------
  // Low-power handling of the first I/O
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LP_AWAKE  = 2'b00,
    LP_HOLD   = 2'b01,
    LP_ACTIVE = 2'b10,
    LP_OFF    = 2'b11
  } licfg_lp_t;

endpackage

// file: logic/licfg_spi_rx.sv
`timescale 1ns/1ps
module licfg_spi_rx
  import licfg_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // SPI pins
  input  wire logic                  spi_sclk,
  input  wire logic                  spi_cs_n,
  input  wire logic                  spi_mosi,
  output logic                       spi_miso,
  // Frame side
  input  wire logic [FRAME_BITS-1:0] tx_word,
  output logic                       frame_valid,
  output logic [FRAME_BITS-1:0]      frame_word
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0]            sync1;
  logic [2:0]            sync2;
  logic [2:0]            sync3;
  logic [2:0]            filt;
  logic [2:0]            pin_in;
  logic                  sclk_prev;
  logic                  cs_prev;
  logic [4:0]            bit_cnt;
  logic [FRAME_BITS-1:0] rx_shift;
  logic [FRAME_BITS-1:0] tx_shift;

  assign pin_in = {spi_mosi, spi_cs_n, spi_sclk};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          sync1[gi] <= (gi == 1) ? 1'b1 : 1'b0;
          sync2[gi] <= (gi == 1) ? 1'b1 : 1'b0;
          sync3[gi] <= (gi == 1) ? 1'b1 : 1'b0;
          filt[gi]  <= (gi == 1) ? 1'b1 : 1'b0;
        end else begin
          sync1[gi] <= pin_in[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          // Only a level seen twice counts, glitches are dropped
          if (sync2[gi] == sync3[gi]) begin
            filt[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Shift engine: sample on rising SCLK, shift out on falling
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sclk_prev <= 1'b0;
      cs_prev   <= 1'b1;
    end else begin
      sclk_prev <= filt[0];
      cs_prev   <= filt[1];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bit_cnt  <= 5'h00;
      rx_shift <= 16'h0000;
    end else if (cs_prev && !filt[1]) begin
      bit_cnt  <= 5'h00;
    end else if (!filt[1] && filt[0] && !sclk_prev) begin
      rx_shift <= {rx_shift[FRAME_BITS-2:0], filt[2]};
      // Saturate so overlong frames are still rejected
      if (bit_cnt != 5'h1F) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_shift <= 16'h0000;
      spi_miso <= 1'b0;
    end else if (cs_prev && !filt[1]) begin
      tx_shift <= tx_word;
      spi_miso <= tx_word[FRAME_BITS-1];
    end else if (filt[1]) begin
      spi_miso <= 1'b0;
    end else if (!filt[0] && sclk_prev) begin
      tx_shift <= {tx_shift[FRAME_BITS-2:0], 1'b0};
      spi_miso <= tx_shift[FRAME_BITS-2];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      frame_valid <= 1'b0;
      frame_word  <= 16'h0000;
    end else begin
      // Frames of any other length are discarded
      frame_valid <= !cs_prev && filt[1] && (bit_cnt == FRAME_COUNT);
      if (!cs_prev && filt[1]) begin
        frame_word <= rx_shift;
      end
    end
  end

endmodule

// file: verification/licfg_props.sv
`timescale 1ns/1ps
module licfg_props
  import licfg_pkg::*;
(
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // Device state
  input wire logic       init_mode,
  input wire logic       low_power_mode,
  input wire logic       cyclic_sense_sel,
  input wire logic       cyclic_active_time,
  input wire logic       overvoltage_main,
  input wire logic       overvoltage_aux,
  // Requests
  input wire logic       io0_hs_req,
  input wire logic       io0_ls_req,
  input wire logic       io1_hs_req,
  input wire logic       io1_ls_req,
  // Outputs
  input wire logic       io0_hs_en,
  input wire logic       io0_ls_en,
  input wire logic       io1_hs_en,
  input wire logic       io1_ls_en,
  input wire logic       first_multipin_lin_switch,
  input wire logic       first_multipin_hs_wake,
  input wire logic       second_multipin_hs_wake,
  input wire logic [7:0] lin_io_init_config
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire [7:0] c  = lin_io_init_config;
  wire       ov = overvoltage_main | overvoltage_aux;
  // Three cycles: low-power entry passes the hold state first, then state lag and output flop
  sequence s_off_plain;
    (low_power_mode && cyclic_sense_sel && !cyclic_active_time && !c[CYC_INV_BIT])[*3];
  endsequence
  reset_clear_a: assert property (disable iff (1'b0) rst |=> c == CFG_RESET)
    else $error("config not cleared");
  init_gate_a: assert property ($changed(c) |-> $past(init_mode) || $past(init_mode, 2))
    else $error("write outside init");
  io1_gate_a: assert property (!c[IO1_OE_BIT] |=> !io1_hs_en && !io1_ls_en)
    else $error("io1 driven while disabled");
  ov_off_a: assert property (c[OVOFF_BIT] && ov |=> !io1_hs_en && !io1_ls_en)
    else $error("io1 not off on overvoltage");
  io1_follow_a: assert property (c[IO1_OE_BIT] && !(c[OVOFF_BIT] && ov) |=>
    io1_hs_en == $past(io1_hs_req) && io1_ls_en == $past(io1_ls_req && !io1_hs_req)) else $error("io1 mismatch");
  mp1_decode_a: assert property (1'b1 |=> first_multipin_lin_switch == ($past(c[MP1_MSB:MP1_LSB]) == MP_LIN_SWITCH)
    && first_multipin_hs_wake == ($past(c[MP1_MSB:MP1_LSB]) == MP_HS_WAKE)) else $error("first multipin");
  mp2_decode_a: assert property (1'b1 |=> second_multipin_hs_wake == ($past(c[MP2_MSB:MP2_LSB]) == MP_HS_WAKE))
    else $error("second multipin");
  io0_awake_a: assert property ((!low_power_mode)[*3] |=> io0_hs_en == $past(c[IO0_OE_BIT] && io0_hs_req)
    && io0_ls_en == $past(c[IO0_OE_BIT] && io0_ls_req && !io0_hs_req)) else $error("io0 awake");
  cyc_off_a: assert property (s_off_plain |=> !io0_hs_en && !io0_ls_en)
    else $error("io0 on in off time");
endmodule
bind licfg_top licfg_props u_props (.*);

// file: verification/licfg_host.sv
`timescale 1ns/1ps
module licfg_host (
  // Clock
  input wire logic ref_clk,
  // SPI pins
  output logic     spi_sclk,
  output logic     spi_cs_n,
  output logic     spi_mosi,
  input wire logic spi_miso
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  task automatic gap(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Eight-cycle phases clear the four-cycle pin filter delay
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    spi_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      gap(8);
      spi_mosi = w[15 - i];
      gap(8);
      r = {r[14:0], spi_miso};
      spi_sclk = 1'b1;
      gap(8);
      spi_sclk = 1'b0;
    end
    gap(8);
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    gap(8);
  endtask
endmodule

// file: verification/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; $display("BAD %0t %h %h", $time, a, b); end end
module tb;
  import licfg_pkg::*;
  logic ref_clk, rst, spi_sclk, spi_cs_n, spi_mosi, spi_miso, init_mode, low_power_mode;
  logic cyclic_sense_sel, cyclic_active_time, overvoltage_main, overvoltage_aux;
  logic io0_hs_req, io0_ls_req, io1_hs_req, io1_ls_req, io0_hs_en, io0_ls_en, io1_hs_en, io1_ls_en;
  logic first_multipin_lin_switch, first_multipin_hs_wake, second_multipin_hs_wake;
  logic [7:0]  lin_io_init_config, m, d;
  logic [15:0] r;
  int          num_errors = 0;
  int          n_compared = 0;
  licfg_top i_dut (.*);
  licfg_host i_host (.*);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    wrap_up;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk;
    logic off1;
    tick(3);
    off1 = !m[2] || (m[7] && (overvoltage_main || overvoltage_aux));
    `CHK(lin_io_init_config, m)
    `CHK(first_multipin_lin_switch, m[4:3] == MP_LIN_SWITCH)
    `CHK(first_multipin_hs_wake, m[4:3] == MP_HS_WAKE)
    `CHK(second_multipin_hs_wake, m[6:5] == MP_HS_WAKE)
    `CHK(io1_hs_en, !off1 && io1_hs_req)
    `CHK(io1_ls_en, !off1 && io1_ls_req && !io1_hs_req)
    `CHK(io0_hs_en, m[1] && io0_hs_req)
    `CHK(io0_ls_en, m[1] && io0_ls_req && !io0_hs_req)
  endtask
  task automatic wr(input logic [15:0] w, input int n, input bit ok);
    i_host.xfer(w, n, r);
    `CHK(r, {READ_HEADER, m} >> (16 - n))
    if (ok) m = w[7:0];
    tick(12);
    chk;
  endtask
  task automatic wrd(input logic [7:0] v);
    wr({CMD_WRITE, CFG_ADDR, 1'b0, v}, 16, 1);
  endtask
  initial begin
    {low_power_mode, cyclic_sense_sel, cyclic_active_time, overvoltage_main, overvoltage_aux} = 5'h00;
    {io0_hs_req, io0_ls_req, io1_hs_req, io1_ls_req} = 4'h0;
    rst = 1'b1;
    init_mode = 1'b1;
    m = CFG_RESET;
    void'($urandom(62));
    tick(6);
    rst = 1'b0;
    chk;
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      // Both multipins get the reserved code once: the second on the last pass, the first on the first pass
      d[6:5] = (i == 1) ? MP_HS_WAKE : 2'(i);
      d[4:3] = 2'(3 - i);
      {io1_hs_req, io1_ls_req, io0_hs_req, io0_ls_req} = 4'($urandom);
      wrd(d);
    end
    $display("code test done");
    for (int k = 0; k < 4; k++) begin
      init_mode = (k != 0);
      wr({(k == 2) ? 2'h2 : CMD_WRITE, (k == 1) ? 5'h08 : CFG_ADDR, 1'b0, 8'($urandom) | 8'h40}, k == 3 ? 15 : 16, 0);
    end
    init_mode = 1'b1;
    $display("refusal test done");
    {io1_hs_req, io1_ls_req} = 2'h2;
    for (int j = 0; j < 2; j++) begin
      wrd(j ? 8'h84 : 8'h04);
      {overvoltage_main, overvoltage_aux} = 2'h2;
      chk;
      {overvoltage_main, overvoltage_aux} = 2'h1;
      chk;
      {overvoltage_main, overvoltage_aux} = 2'h0;
    end
    $display("overvoltage test done");
    {io0_hs_req, io0_ls_req} = 2'h2;
    for (int j = 0; j < 2; j++) begin
      wrd({6'h00, 1'b1, j[0]});
      {low_power_mode, cyclic_sense_sel, cyclic_active_time} = 3'h7;
      tick(4);
      `CHK({io0_hs_en, io0_ls_en}, 2'h2)
      cyclic_active_time = 1'b0;
      tick(4);
      `CHK({io0_hs_en, io0_ls_en}, {1'b0, j[0]})
      {low_power_mode, cyclic_sense_sel} = 2'h0;
    end
    $display("cyclic test done");
    rst = 1'b1;
    tick(4);
    rst = 1'b0;
    m = CFG_RESET;
    chk;
    $display("second reset done");
    wrap_up;
  end
endmodule
